// ---- rtl/spbm_params.svh ----
// Constants for the protection bit map descriptor block
// ============================================================
// Overview of operation
// - Sector type codes 01H to 04H
// - Bottom-up: 8K x4, 32K, 64K run, 32K, 8K x4
// - 8K type 2, 32K type 3, 64K type 4
// - 64K block count is two to m minus two
// - m is 4 to 8 by density
// - 8K and 32K counts hold exponent n
// - Adder c signed; 00H means bit zero
// - Locations advance one per 64K or 32K block, start to end
// - Bottom 8K adders 0FFH and 04H
// - 64K 00H to 0FCH; 32K at 0FDH, 0FEH
// - Top 8K adders 07H and 0EH
// - 8K odd locations read lock, even write
// - Uniform 4K sectors are not described
// - Each contiguous run is its own section
// - Fields: type, count, first, last location
// - Word: type 7:0, count 15:8, first, last
`ifndef SPBM_PARAMS_SVH
`define SPBM_PARAMS_SVH

// ============================================================
// Sector type codes
`define SPBM_TYPE_4K 8'h01
`define SPBM_TYPE_8K 8'h02
`define SPBM_TYPE_32K 8'h03
`define SPBM_TYPE_64K 8'h04

// ============================================================
// Count fields and adders
`define SPBM_N_8K 8'h02
`define SPBM_N_32K 8'h00
`define SPBM_ADD_BOT8_FIRST 8'hFF
`define SPBM_ADD_BOT8_LAST 8'h04
`define SPBM_ADD_64_FIRST 8'h00
`define SPBM_ADD_64_LAST 8'hFC
`define SPBM_ADD_LO32 8'hFD
`define SPBM_ADD_HI32 8'hFE
`define SPBM_ADD_TOP8_FIRST 8'h07
`define SPBM_ADD_TOP8_LAST 8'h0E

// ============================================================
// Field positions inside a descriptor word
`define SPBM_FLD_TYPE 7:0
`define SPBM_FLD_COUNT 15:8
`define SPBM_FLD_FIRST 23:16
`define SPBM_FLD_LAST 31:24

// ============================================================
// Density constant and section count
`define SPBM_M_MIN 4'h4
`define SPBM_M_MAX 4'h8
`define SPBM_M_RESET 4'h7
`define SPBM_NUM_SECT 3'h5

`endif

// ---- rtl/spbm_pkg.sv ----
// Types shared by the protection bit map descriptor block
package spbm_pkg;

	typedef logic [2:0] spbm_sect_type;
	typedef logic [31:0] spbm_word_type;
	typedef logic [8:0] spbm_loc_type;
	typedef logic [23:0] spbm_addr_type;

	typedef enum logic [2:0] {
		SPBM_SEC_BOT8,
		SPBM_SEC_LO32,
		SPBM_SEC_RUN64,
		SPBM_SEC_HI32,
		SPBM_SEC_TOP8
	} spbm_sec_type;

endpackage

// ---- rtl/spbm_sect_if.sv ----
// Carrier between the descriptor table and the read logic
`timescale 1ns/1ps
`default_nettype none
interface spbm_sect_if;
	import spbm_pkg::*;
	logic [2:0] sel;
	logic [3:0] density_m;
	spbm_word_type word;
	logic hit;
	modport table_side (input sel, input density_m, output word, output hit);
	modport user_side (output sel, output density_m, input word, input hit);
endinterface
`default_nettype wire

// ---- rtl/spbm_table.sv ----
// Descriptor table: one four-field word per section
`timescale 1ns/1ps
`default_nettype none
`include "spbm_params.svh"
module spbm_table
	import spbm_pkg::*;
(
	// Section select and descriptor word
	spbm_sect_if.table_side bus
);

	// ============================================================
	// Word assembly
	function automatic spbm_word_type pack_desc(input logic [7:0] typ, input logic [7:0] cnt,
			input logic [7:0] first, input logic [7:0] last);
		spbm_word_type w;
		w = '0;
		w[`SPBM_FLD_TYPE] = typ;
		w[`SPBM_FLD_COUNT] = cnt;
		w[`SPBM_FLD_FIRST] = first;
		w[`SPBM_FLD_LAST] = last;
		return w;
	endfunction

	// ============================================================
	// Sections from the bottom of memory upward; 4K sectors have no entry
	always_comb begin
		bus.hit = 1'b1;
		unique case (bus.sel)
			3'h0: bus.word = pack_desc(`SPBM_TYPE_8K, `SPBM_N_8K,
				`SPBM_ADD_BOT8_FIRST, `SPBM_ADD_BOT8_LAST);
			3'h1: bus.word = pack_desc(`SPBM_TYPE_32K, `SPBM_N_32K,
				`SPBM_ADD_LO32, `SPBM_ADD_LO32);
			3'h2: bus.word = pack_desc(`SPBM_TYPE_64K, {4'h0, bus.density_m},
				`SPBM_ADD_64_FIRST, `SPBM_ADD_64_LAST);
			3'h3: bus.word = pack_desc(`SPBM_TYPE_32K, `SPBM_N_32K,
				`SPBM_ADD_HI32, `SPBM_ADD_HI32);
			3'h4: bus.word = pack_desc(`SPBM_TYPE_8K, `SPBM_N_8K,
				`SPBM_ADD_TOP8_FIRST, `SPBM_ADD_TOP8_LAST);
			default: begin
				bus.word = '0;
				bus.hit = 1'b0;
			end
		endcase
	end

endmodule
`default_nettype wire

// ---- rtl/spbm_top.sv ----
// Protection bit map descriptor read port with decoded locations
`timescale 1ns/1ps
`default_nettype none
`include "spbm_params.svh"
module spbm_top
	import spbm_pkg::*;
(
	// Clock, reset, enable
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	// Density strap, caught while reset is high
	input wire logic [3:0] i_density_m,
	// Read request
	input wire logic i_rd_req,
	input wire logic [2:0] i_rd_sect,
	// Read answer
	output logic o_rd_valid,
	output logic o_rd_err,
	output logic [31:0] o_rd_word,
	output logic [8:0] o_rd_first_loc,
	output logic [8:0] o_rd_last_loc,
	output logic [8:0] o_rd_blk_count,
	output logic [23:0] o_rd_base_addr,
	output logic o_rd_split_lock,
	// Status
	output logic [3:0] o_density_m,
	output logic o_density_err
);

	// ============================================================
	// Decoding shared by first and last location
	function automatic spbm_loc_type loc_of(input logic [7:0] c, input logic [3:0] m);
		logic [9:0] base;
		logic [9:0] sum;
		base = 10'h001 + (10'h001 << m);
		sum = base + {{2{c[7]}}, c};
		if (c == 8'h00) begin
			return 9'h000;
		end
		return sum[8:0];
	endfunction

	// Bytes of 64K blocks below the upper sections
	function automatic spbm_addr_type run64_bytes(input logic [3:0] m);
		logic [24:0] blocks;
		blocks = (25'h0000001 << m) - 25'h0000002;
		// At most 254 blocks, so eight bits of count above a 64K stride
		return {blocks[7:0], 16'h0000};
	endfunction

	// ============================================================
	// Density capture; out of range values fall back to the default
	logic [3:0] density_r;
	logic [3:0] density_nxt;
	logic density_err_r;
	logic density_err_nxt;

	always_comb begin
		density_nxt = density_r;
		density_err_nxt = density_err_r;
		if (i_rst) begin
			if (i_density_m < `SPBM_M_MIN || i_density_m > `SPBM_M_MAX) begin
				density_nxt = `SPBM_M_RESET;
				density_err_nxt = 1'b1;
			end else begin
				density_nxt = i_density_m;
				density_err_nxt = 1'b0;
			end
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst || i_ce) begin
			density_r <= density_nxt;
			density_err_r <= density_err_nxt;
		end
	end

	// ============================================================
	// Descriptor table
	spbm_sect_if sect_bus ();
	assign sect_bus.sel = i_rd_sect;
	assign sect_bus.density_m = density_r;

	spbm_table u_table (
		.bus(sect_bus.table_side)
	);

	// ============================================================
	// Answer registers
	logic valid_r;
	logic valid_nxt;
	logic err_r;
	logic err_nxt;
	spbm_word_type word_r;
	spbm_word_type word_nxt;
	spbm_loc_type first_r;
	spbm_loc_type first_nxt;
	spbm_loc_type last_r;
	spbm_loc_type last_nxt;
	spbm_loc_type count_r;
	spbm_loc_type count_nxt;
	spbm_addr_type base_r;
	spbm_addr_type base_nxt;
	logic split_r;
	logic split_nxt;
	spbm_loc_type first_w;
	spbm_loc_type last_w;

	assign first_w = (sect_bus.word[`SPBM_FLD_TYPE] == `SPBM_TYPE_64K)
		? 9'h000 : loc_of(sect_bus.word[`SPBM_FLD_FIRST], density_r);
	assign last_w = loc_of(sect_bus.word[`SPBM_FLD_LAST], density_r);

	always_comb begin
		valid_nxt = 1'b0;
		err_nxt = err_r;
		word_nxt = word_r;
		first_nxt = first_r;
		last_nxt = last_r;
		count_nxt = count_r;
		base_nxt = base_r;
		split_nxt = split_r;
		if (i_rd_req) begin
			valid_nxt = 1'b1;
			err_nxt = ~sect_bus.hit;
			word_nxt = sect_bus.word;
			first_nxt = first_w;
			last_nxt = last_w;
			// Range length from the location span, one per 64K or 32K block
			count_nxt = last_w - first_w + 9'h001;
			// Only 8K sections pair read and write lock bits
			split_nxt = (sect_bus.word[`SPBM_FLD_TYPE] == `SPBM_TYPE_8K);
			unique case (i_rd_sect)
				3'h0: base_nxt = 24'h000000;
				3'h1: base_nxt = 24'h008000;
				3'h2: base_nxt = 24'h010000;
				3'h3: base_nxt = 24'h010000 + run64_bytes(density_r);
				3'h4: base_nxt = 24'h018000 + run64_bytes(density_r);
				default: begin
					base_nxt = 24'h000000;
					first_nxt = 9'h000;
					last_nxt = 9'h000;
					count_nxt = 9'h000;
					split_nxt = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			valid_r <= 1'b0;
			err_r <= 1'b0;
			word_r <= 32'h00000000;
			first_r <= 9'h000;
			last_r <= 9'h000;
			count_r <= 9'h000;
			base_r <= 24'h000000;
			split_r <= 1'b0;
		end else if (i_ce) begin
			valid_r <= valid_nxt;
			err_r <= err_nxt;
			word_r <= word_nxt;
			first_r <= first_nxt;
			last_r <= last_nxt;
			count_r <= count_nxt;
			base_r <= base_nxt;
			split_r <= split_nxt;
		end
	end

	// ============================================================
	// Outputs
	assign o_rd_valid = valid_r;
	assign o_rd_err = err_r;
	assign o_rd_word = word_r;
	assign o_rd_first_loc = first_r;
	assign o_rd_last_loc = last_r;
	assign o_rd_blk_count = count_r;
	assign o_rd_base_addr = base_r;
	assign o_rd_split_lock = split_r;
	assign o_density_m = density_r;
	assign o_density_err = density_err_r;

endmodule
`default_nettype wire

// ---- testbench/spbm_top_sva.sv ----
// Concurrent checks on the descriptor read port
`timescale 1ns/1ps
`default_nettype none
module spbm_top_sva (
	// Clock and request
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic i_rd_req,
	input wire logic [2:0] i_rd_sect,
	// Answer and status
	input wire logic o_rd_valid,
	input wire logic o_rd_err,
	input wire logic [31:0] o_rd_word,
	input wire logic [8:0] o_rd_first_loc,
	input wire logic [8:0] o_rd_last_loc,
	input wire logic [8:0] o_rd_blk_count,
	input wire logic o_rd_split_lock,
	input wire logic [3:0] o_density_m
);
	// ====
	// One clock domain, so one clocking and one disable
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	logic tk;
	assign tk = i_ce && i_rd_req;
	AST_VALID: assert property (tk |=> o_rd_valid)
		else $error("valid missing");
	AST_NO_VALID: assert property (i_ce && !i_rd_req |=> !o_rd_valid)
		else $error("valid without read");
	AST_BOT8: assert property (tk && i_rd_sect == 3'h0 |=> o_rd_word == 32'h04FF0202)
		else $error("bottom word wrong");
	AST_RUN64: assert property (tk && i_rd_sect == 3'h2 |=> o_rd_first_loc == 9'h000
		&& o_rd_last_loc == (9'h001 << o_density_m) + 9'h1FD) else $error("run loc wrong");
	AST_TOP8: assert property (tk && i_rd_sect == 3'h4 |=> o_rd_word == 32'h0E070202)
		else $error("top word wrong");
	AST_REFUSED: assert property (tk && i_rd_sect > 3'h4 |=> o_rd_err && o_rd_word == 32'h0)
		else $error("bad section taken");
	AST_COUNT: assert property (o_rd_valid |-> o_rd_blk_count ==
		(o_rd_err ? 9'h000 : o_rd_last_loc - o_rd_first_loc + 9'h001)) else $error("span wrong");
	AST_SPLIT: assert property (o_rd_valid |-> o_rd_split_lock == (o_rd_word[7:0] == 8'h02))
		else $error("split flag wrong");
	cover property (tk && i_rd_sect == 3'h2);
	cover property (tk ##1 tk);
	cover property (tk && i_rd_sect == 3'h7);
endmodule
bind spbm_top spbm_top_sva spbm_top_sva_i (.i_ref_clk, .i_rst, .i_ce, .i_rd_req, .i_rd_sect,
	.o_rd_valid, .o_rd_err, .o_rd_word, .o_rd_first_loc, .o_rd_last_loc, .o_rd_blk_count,
	.o_rd_split_lock, .o_density_m);
`default_nettype wire

// ---- testbench/spbm_host_model.sv ----
// Host decoder of one descriptor word into protection bit locations
`timescale 1ns/1ps
`default_nettype none
module spbm_host_model (
	// Descriptor and density
	input wire logic [31:0] i_word,
	input wire logic [3:0] i_density_m,
	// Decoded locations
	output logic [8:0] o_first_loc,
	output logic [8:0] o_last_loc
);
	// ====
	// Nine bits hold 2^8+1+14; extend the sign or negative adders wrap
	logic [8:0] b;
	assign b = (9'h001 << i_density_m) + 9'h001;
	assign o_first_loc = (i_word[23:16] == 8'h00) ? 9'h000
		: b + {i_word[23], i_word[23:16]};
	assign o_last_loc = (i_word[31:24] == 8'h00) ? 9'h000
		: b + {i_word[31], i_word[31:24]};
endmodule
`default_nettype wire

// ---- testbench/spbm_top_tb_top.sv ----
// Self-checking bench for the descriptor read port
`timescale 1ns/1ps
`default_nettype none
module spbm_top_tb_top;
	// ====
	// Stimulus, outputs and model state
	logic i_ref_clk = 1'b0, i_rst = 1'b1, i_ce = 1'b1, i_rd_req = 1'b0, ev = 1'b0, de = 1'b0;
	logic [3:0] i_density_m = 4'h7, o_density_m;
	logic [2:0] i_rd_sect = 3'h0;
	logic o_rd_valid, o_rd_err, o_rd_split_lock, o_density_err;
	logic [31:0] o_rd_word;
	logic [8:0] o_rd_first_loc, o_rd_last_loc, o_rd_blk_count, h_first, h_last;
	logic [23:0] o_rd_base_addr;
	int num_errors = 0, n_tests = 0, m = 7, sq[$];
	int dl[7] = '{4, 5, 6, 7, 8, 3, 15};
	always #12.5 i_ref_clk = ~i_ref_clk;
	spbm_top spbm_top_i (.i_ref_clk, .i_rst, .i_ce, .i_density_m, .i_rd_req, .i_rd_sect,
		.o_rd_valid, .o_rd_err, .o_rd_word, .o_rd_first_loc, .o_rd_last_loc, .o_rd_blk_count,
		.o_rd_base_addr, .o_rd_split_lock, .o_density_m, .o_density_err);
	spbm_host_model spbm_host_model_i (.i_word(o_rd_word), .i_density_m(o_density_m),
		.o_first_loc(h_first), .o_last_loc(h_last));
	// ====
	// Model: field k of the answer for section s, s below zero after reset
	function automatic logic [31:0] ex(int k, int s);
		int b[5] = '{32'h04FF0202, 32'hFDFD0003, 32'hFC000004, 32'hFEFE0003, 32'h0E070202};
		logic [31:0] w;
		int f, l;
		if (s < 0 || s > 4) return 32'(k == 6 && s > 4);
		w = b[s] | (s == 2 ? m << 8 : 0);
		l = (1 << m) + 1 + $signed(w[31:24]);
		f = (w[23:16] == 8'h00) ? 0 : (1 << m) + 1 + $signed(w[23:16]);
		case (k)
			0: return w;
			1: return f;
			2: return l;
			3: return l - f + 1;
			4: return (s > 0 ? 32'h8000 : 0) + (s > 1 ? 32'h8000 : 0)
				+ (s > 2 ? ((1 << m) - 2) << 16 : 0) + (s > 3 ? 32'h8000 : 0);
			5: return 32'(s == 0 || s == 4);
			default: return 32'h0;
		endcase
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic step(input logic r, input logic [2:0] s, input logic c);
		int ls;
		@(negedge i_ref_clk);
		// Update from what the last rising edge saw, before driving anew
		if (i_ce) begin
			ev = i_rd_req;
			if (i_rd_req) sq.push_back(i_rd_sect);
		end
		ls = sq.size() ? sq[$] : -1;
		chk(32'(o_rd_valid), 32'(ev));
		chk(o_rd_word, ex(0, ls));
		chk(32'(o_rd_first_loc), ex(1, ls));
		chk(32'(o_rd_last_loc), ex(2, ls));
		chk(32'(o_rd_blk_count), ex(3, ls));
		chk(32'(o_rd_base_addr), ex(4, ls));
		chk(32'(o_rd_split_lock), ex(5, ls));
		chk(32'(o_rd_err), ex(6, ls));
		chk(32'(h_first), ex(1, ls));
		chk(32'(h_last), ex(2, ls));
		chk(32'(o_density_m), 32'(m));
		chk(32'(o_density_err), 32'(de));
		i_rd_req = r;
		i_rd_sect = s;
		i_ce = c;
	endtask
	task automatic rst(input int d);
		@(negedge i_ref_clk);
		i_rst = 1'b1;
		i_ce = 1'b1;
		i_rd_req = 1'b0;
		i_density_m = 4'(d);
		m = (d >= 4 && d <= 8) ? d : 7;
		de = (d < 4 || d > 8);
		repeat (12) @(negedge i_ref_clk);
		i_rst = 1'b0;
		sq.delete();
		ev = 1'b0;
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// ====
	// Every density, every section back to back, then random traffic
	initial begin
		void'($urandom(32'h87C1));
		foreach (dl[i]) begin
			rst(dl[i]);
			for (int s = 0; s < 8; s++) step(1'b1, 3'(s), 1'b1);
			step(1'b1, 3'h2, 1'b0);
			step(1'b0, 3'h0, 1'b1);
			step(1'b0, 3'h0, 1'b1);
			$display("test density %0d done", dl[i]);
		end
		repeat (300) step(1'($urandom), 3'($urandom), $urandom_range(3, 0) != 0);
		step(1'b0, 3'h0, 1'b1);
		$display("test random done");
		summarize();
	end
	initial begin
		#(25 * 5000);
		num_errors++;
		summarize();
	end
endmodule
`default_nettype wire
